/* File: design/vad_tone_gain.sv */
// Window stage, prediction gain tone test, energy and flag packing.
`timescale 1ns/1ps
module vad_tone_gain #(
  parameter bit DOWNLINK   = 1'b1,
  parameter int DATA_W     = 16,
  parameter int ACF_W      = 32,
  parameter int FIFO_DEPTH = 32,
  parameter int EN_W       = 76
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         sample_valid,
  input  wire logic [DATA_W-1:0]            sample_data,
  output logic                              sample_ready,
  output logic                              win_valid,
  output logic [DATA_W-1:0]                 win_data,
  output logic                              win_last,
  input  wire logic                         win_ready,
  input  wire logic                         params_valid,
  input  wire logic [3:0][DATA_W-1:0]       reflection_coefficient,
  input  wire logic [8:0][DATA_W-1:0]       filt_coef,
  input  wire logic [8:0][ACF_W-1:0]        acf,
  input  wire logic                         pole_low,
  input  wire logic                         vad_decision,
  input  wire logic                         speech_frame_flag,
  input  wire logic [DATA_W-1:0]            first_coded_parameter,
  input  wire logic [DATA_W-1:0]            second_coded_parameter,
  output logic                              params_ack,
  output logic                              frame_done,
  output logic                              tone,
  output logic signed [EN_W-1:0]            energy,
  output logic [DATA_W-1:0]                 first_word,
  output logic [DATA_W-1:0]                 second_word
);

  // ---------------- Sample path ----------------
  logic              f_valid;
  logic [DATA_W-1:0] f_data;
  logic              f_ready;
  logic              f_take;
  logic [7:0]        idx_q;
  logic [6:0]        hidx;
  logic signed [32:0] wprod;
  logic signed [32:0] wrnd;
  logic              win_valid_q;
  logic [DATA_W-1:0] win_data_q;
  logic              win_last_q;
  logic              idx_end;

  sample_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (sample_valid),
    .in_data   (sample_data),
    .in_ready  (sample_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_ready)
  );

  // The output register drains only when the consumer takes its word, so a
  // stalled consumer backs up through the FIFO to the sample source.
  assign f_ready = !win_valid_q || win_ready;
  assign f_take  = f_valid && f_ready;
  assign idx_end = (idx_q == 8'(vad_tone_pkg::FRAME_LEN - 1));
  // The second half of the frame reuses the table mirrored.
  assign hidx    = (idx_q < 8'(vad_tone_pkg::HALF_LEN)) ? idx_q[6:0]
                 : 7'(8'(vad_tone_pkg::FRAME_LEN - 1) - idx_q);
  assign wprod   = 33'($signed(f_data)
                 * $signed({1'b0, vad_tone_pkg::HANN[hidx]}));
  assign wrnd    = wprod + $signed(vad_tone_pkg::ROUND_HALF);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idx_q <= '0;
    end else if (f_take) begin
      idx_q <= idx_end ? 8'h00 : 8'(idx_q + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_valid_q <= 1'b0;
      win_data_q  <= '0;
      win_last_q  <= 1'b0;
    end else if (f_ready) begin
      win_valid_q <= f_valid;
      win_data_q  <= f_take ? wrnd[30:15] : win_data_q;
      win_last_q  <= f_take && idx_end;
    end
  end

  assign win_valid = win_valid_q;
  assign win_data  = win_data_q;
  assign win_last  = win_last_q;

  // ---------------- Frame parameter path ----------------
  vad_tone_pkg::state_t state_q;
  vad_tone_pkg::state_t state_d;
  logic [1:0]  gcnt_q;
  logic [15:0] pe_q;
  logic [3:0]  ii_q;
  logic [3:0]  kk_q;
  logic signed [35:0]     r_acc_q;
  logic signed [EN_W-1:0] en_acc_q;

  logic signed [DATA_W-1:0] refl;
  logic signed [31:0]       refl_sq;
  logic [15:0]              sq15;
  logic [15:0]              one_minus;
  logic [31:0]              pe_prod;
  logic                     skip_gain;
  logic                     tone_d;
  logic signed [31:0]       term;
  logic signed [35:0]       r_sum;
  logic signed [67:0]       rp;
  logic signed [EN_W-1:0]   en_add;
  logic signed [EN_W-1:0]   en_next;
  logic                     last_k;
  logic                     last_all;

  assign refl      = $signed(reflection_coefficient[gcnt_q]);
  assign refl_sq   = refl * refl;
  // Only -1 squared reaches bit 30; it saturates instead of wrapping.
  assign sq15      = refl_sq[30] ? vad_tone_pkg::Q15_ONE : refl_sq[30:15];
  assign one_minus = vad_tone_pkg::Q15_ONE - sq15;
  assign pe_prod   = pe_q * one_minus;
  assign skip_gain = !DOWNLINK || pole_low;
  assign tone_d    = !skip_gain && (pe_q < vad_tone_pkg::TONE_THRESH);

  assign term     = $signed(filt_coef[kk_q])
                  * $signed(filt_coef[4'(kk_q + ii_q)]);
  assign r_sum    = r_acc_q + 36'(term);
  assign rp       = r_sum * $signed(acf[ii_q]);
  assign en_add   = (ii_q == 4'h0) ? EN_W'(rp) : EN_W'(rp) <<< 1;
  assign en_next  = en_acc_q + en_add;
  assign last_k   = (kk_q == 4'(vad_tone_pkg::FILT_ORDER) - ii_q);
  assign last_all = last_k && (ii_q == 4'(vad_tone_pkg::FILT_ORDER));

  always_comb begin
    state_d = state_q;
    case (state_q)
      vad_tone_pkg::ST_IDLE: begin
        if (params_valid) begin
          state_d = skip_gain ? vad_tone_pkg::ST_ENERGY
                  : vad_tone_pkg::ST_GAIN;
        end
      end
      vad_tone_pkg::ST_GAIN: begin
        if (gcnt_q == 2'(vad_tone_pkg::NUM_RC - 1)) begin
          state_d = vad_tone_pkg::ST_ENERGY;
        end
      end
      vad_tone_pkg::ST_ENERGY: begin
        if (last_all) begin
          state_d = vad_tone_pkg::ST_DONE;
        end
      end
      vad_tone_pkg::ST_DONE: begin
        state_d = vad_tone_pkg::ST_IDLE;
      end
      default: begin
        state_d = vad_tone_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= vad_tone_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Gain stage: product of one minus each coefficient squared.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gcnt_q <= '0;
      pe_q   <= vad_tone_pkg::PE_INIT;
    end else if (state_q == vad_tone_pkg::ST_IDLE) begin
      gcnt_q <= '0;
      pe_q   <= vad_tone_pkg::PE_INIT;
    end else if (state_q == vad_tone_pkg::ST_GAIN) begin
      gcnt_q <= 2'(gcnt_q + 1'b1);
      pe_q   <= pe_prod[30:15];
    end
  end

  // Energy: one coefficient product per cycle, 45 cycles per frame.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ii_q     <= '0;
      kk_q     <= '0;
      r_acc_q  <= '0;
      en_acc_q <= '0;
    end else if (state_q != vad_tone_pkg::ST_ENERGY) begin
      ii_q     <= '0;
      kk_q     <= '0;
      r_acc_q  <= '0;
      en_acc_q <= '0;
    end else if (last_k) begin
      ii_q     <= 4'(ii_q + 1'b1);
      kk_q     <= '0;
      r_acc_q  <= '0;
      en_acc_q <= en_next;
    end else begin
      kk_q    <= 4'(kk_q + 1'b1);
      r_acc_q <= r_sum;
    end
  end

  logic                   ack_q;
  logic                   done_q;
  logic                   tone_q;
  logic signed [EN_W-1:0] energy_q;
  logic [DATA_W-1:0]      first_q;
  logic [DATA_W-1:0]      second_q;
  logic                   finish;

  assign finish = (state_q == vad_tone_pkg::ST_ENERGY) && last_all;

  // All results change together once per frame so later stages never see
  // a tone from one frame beside words from another.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q    <= 1'b0;
      done_q   <= 1'b0;
      tone_q   <= 1'b0;
      energy_q <= '0;
      first_q  <= '0;
      second_q <= '0;
    end else begin
      ack_q  <= finish;
      done_q <= finish;
      if (finish) begin
        tone_q   <= tone_d;
        energy_q <= en_next;
        first_q  <= {vad_decision,
                     first_coded_parameter[vad_tone_pkg::FLAG_BIT-1:0]};
        second_q <= {speech_frame_flag,
                     second_coded_parameter[vad_tone_pkg::FLAG_BIT-1:0]};
      end
    end
  end

  assign params_ack  = ack_q;
  assign frame_done  = done_q;
  assign tone        = tone_q;
  assign energy      = energy_q;
  assign first_word  = first_q;
  assign second_word = second_q;
endmodule

/* File: pkg/vad_tone_pkg.sv */
// Constants, states and the window table for the tone and energy block.
package vad_tone_pkg;

  localparam int          FRAME_LEN   = 160;
  localparam int          HALF_LEN    = 80;
  localparam int          NUM_RC      = 4;
  localparam int          FILT_ORDER  = 8;
  localparam int          FLAG_BIT    = 15;
  localparam logic [15:0] TONE_THRESH = 16'h05B8;
  localparam logic [15:0] PE_INIT     = 16'h7FFF;
  localparam logic [15:0] Q15_ONE     = 16'h7FFF;
  localparam logic [32:0] ROUND_HALF  = 33'h000004000;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_GAIN   = 4'b0010,
    ST_ENERGY = 4'b0100,
    ST_DONE   = 4'b1000
  } state_t;

  localparam logic [15:0] HANN [HALF_LEN] = '{
    16'h0000, 16'h000C, 16'h0033, 16'h0072, 16'h00CC, 16'h013E, 16'h01CA,
    16'h026E, 16'h032B, 16'h0401, 16'h04EE, 16'h05F3, 16'h070F, 16'h0842,
    16'h098C, 16'h0AEB, 16'h0C5F, 16'h0DE8, 16'h0F84, 16'h1135, 16'h12F8,
    16'h14CD, 16'h16B3, 16'h18AA, 16'h1AB0, 16'h1CC5, 16'h1EE9, 16'h2119,
    16'h2356, 16'h259F, 16'h27F2, 16'h2A4F, 16'h2CB4, 16'h2F21, 16'h3195,
    16'h340E, 16'h368C, 16'h390F, 16'h3B93, 16'h3E1A, 16'h40A1, 16'h4328,
    16'h45AE, 16'h4832, 16'h4AB2, 16'h4D2E, 16'h4FA5, 16'h5216, 16'h547F,
    16'h56E0, 16'h5938, 16'h5B86, 16'h5DC9, 16'h5FFF, 16'h622A, 16'h6446,
    16'h6654, 16'h6853, 16'h6A41, 16'h6C1F, 16'h6DEB, 16'h6FA5, 16'h714B,
    16'h72DE, 16'h745D, 16'h75C7, 16'h771B, 16'h7859, 16'h7981, 16'h7A91,
    16'h7B8A, 16'h7C6C, 16'h7D35, 16'h7DE6, 16'h7E7E, 16'h7EFD, 16'h7F63,
    16'h7FB0, 16'h7FE3, 16'h7FFC
  };

endpackage

/* File: design/sample_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int W = 16,
  parameter int D = 32
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   count_q;
  logic [AW:0]   count_d;
  logic          ready_q;
  logic          push;
  logic          pop;

  // Ready is registered so the source never sees a combinational path.
  assign push      = in_valid && ready_q;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data  = mem[rd_q];
  assign in_ready  = ready_q;
  assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wr_q    <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q    <= pop ? AW'(rd_q + 1'b1) : rd_q;
      count_q <= count_d;
      ready_q <= (count_d < (AW+1)'(D));
    end
  end
endmodule

/* File: dv/vad_tone_gain_asserts.sv */
// Concurrent checks on the ports of the tone, energy and flag block.
`timescale 1ns/1ps
module vad_tone_gain_asserts #(
  parameter bit DOWNLINK = 1'b1
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        params_valid,
  input wire logic        pole_low,
  input wire logic        vad_decision,
  input wire logic        speech_frame_flag,
  input wire logic [15:0] first_coded_parameter,
  input wire logic [15:0] second_coded_parameter,
  input wire logic        params_ack,
  input wire logic        frame_done,
  input wire logic        tone,
  input wire logic [15:0] first_word,
  input wire logic [15:0] second_word,
  input wire logic        win_valid,
  input wire logic [15:0] win_data,
  input wire logic        win_ready
);
  logic busy_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) busy_q <= 1'b0;
    else if (params_ack) busy_q <= 1'b0;
    else if (params_valid) busy_q <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ack_done_pair: assert property (params_ack == frame_done)
    else $error("ack and done differ");
  a_ack_one_cycle: assert property (params_ack |=> !params_ack)
    else $error("ack longer than one cycle");
  a_tone_held: assert property (!frame_done |-> $stable(tone))
    else $error("tone changed between frames");
  // The windows allow one edge of slack on either reading of the latency.
  a_gain_time: assert property ($rose(busy_q) && DOWNLINK
    && !pole_low |-> ##[48:50] params_ack)
    else $error("gain path latency wrong");
  a_skip_time: assert property ($rose(busy_q)
    && (pole_low || !DOWNLINK) |-> ##[44:46] params_ack)
    else $error("skip path latency wrong");
  a_tone_cleared: assert property (frame_done
    && (pole_low || !DOWNLINK) |-> !tone)
    else $error("tone set while gain stage skipped");
  a_flag_first: assert property (frame_done |-> first_word ==
    {vad_decision, first_coded_parameter[14:0]}) else $error("first word");
  a_flag_second: assert property (frame_done |-> second_word ==
    {speech_frame_flag, second_coded_parameter[14:0]}) else $error("second");
  a_win_hold: assert property (win_valid && !win_ready
    |=> win_valid && $stable(win_data)) else $error("window output dropped");
endmodule
bind vad_tone_gain vad_tone_gain_asserts #(.DOWNLINK(DOWNLINK)) chk_u (
  .clk(clk), .rstn(rstn), .params_valid(params_valid), .pole_low(pole_low),
  .vad_decision(vad_decision), .speech_frame_flag(speech_frame_flag),
  .first_coded_parameter(first_coded_parameter),
  .second_coded_parameter(second_coded_parameter), .tone(tone),
  .params_ack(params_ack), .frame_done(frame_done), .win_ready(win_ready),
  .first_word(first_word), .second_word(second_word),
  .win_valid(win_valid), .win_data(win_data));

/* File: dv/encoder_model.sv */
// Encoder side: offers one frame and holds it until acknowledged.
`timescale 1ns/1ps
module encoder_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic params_ack,
  output logic      params_valid
);
  initial params_valid = 1'b0;
  always @(posedge clk) begin
    if (params_ack) params_valid <= #1 1'b0;
    else if (go) params_valid <= #1 1'b1;
  end
endmodule

/* File: dv/tb_vad_tone_gain.sv */
// Testbench for the tone, energy and flag packing block.
`timescale 1ns/1ps
module tb_vad_tone_gain;
  logic               clk, rstn, go, sample_valid, sample_ready, win_ready;
  logic               win_valid, win_last, params_valid, params_ack, tone;
  logic               pole_low, vad_decision, speech_frame_flag, frame_done;
  logic [15:0]        sample_data, win_data, p1, p2, first_word, second_word;
  logic               up_tone, up_ack, up_valid;
  logic [3:0][15:0]   refl_coef;
  logic [8:0][15:0]   coef;
  logic [8:0][31:0]   acf;
  logic signed [75:0] energy;
  int                 n_mismatch, n_checks, cyc;

  vad_tone_gain dut_u (.clk(clk), .rstn(rstn), .sample_valid(sample_valid),
    .sample_data(sample_data), .sample_ready(sample_ready),
    .win_valid(win_valid), .win_data(win_data), .win_last(win_last),
    .win_ready(win_ready), .params_valid(params_valid),
    .reflection_coefficient(refl_coef), .filt_coef(coef), .acf(acf),
    .pole_low(pole_low), .vad_decision(vad_decision),
    .speech_frame_flag(speech_frame_flag), .first_coded_parameter(p1),
    .second_coded_parameter(p2), .params_ack(params_ack),
    .frame_done(frame_done), .tone(tone), .energy(energy),
    .first_word(first_word), .second_word(second_word));
  encoder_model pm_u (.clk(clk), .go(go), .params_ack(params_ack),
    .params_valid(params_valid));

  // Uplink copy sees the same frames; its tone must never leave zero.
  vad_tone_gain #(.DOWNLINK(1'b0)) dut_up_u (.clk(clk), .rstn(rstn),
    .sample_valid(1'b0), .sample_data(16'h0000), .sample_ready(),
    .win_valid(), .win_data(), .win_last(), .win_ready(1'b0),
    .params_valid(up_valid), .reflection_coefficient(refl_coef),
    .filt_coef(coef), .acf(acf), .pole_low(pole_low),
    .vad_decision(vad_decision), .speech_frame_flag(speech_frame_flag),
    .first_coded_parameter(p1), .second_coded_parameter(p2),
    .params_ack(up_ack), .frame_done(), .tone(up_tone), .energy(),
    .first_word(), .second_word());
  encoder_model pm_up_u (.clk(clk), .go(go), .params_ack(up_ack),
    .params_valid(up_valid));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_num(string nm, logic [75:0] e, logic [75:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_flag(string nm, logic e, logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic signed [75:0] e_ref();
    logic signed [75:0] r, s;
    s = 0;
    for (int i = 0; i < 9; i++) begin
      r = 0;
      for (int k = 0; k + i < 9; k++)
        r += 76'(signed'(coef[k])) * 76'(signed'(coef[k+i]));
      s += (i == 0 ? 76'sd1 : 76'sd2) * r * 76'(signed'(acf[i]));
    end
    return s;
  endfunction

  // One frame through the encoder model; inputs hold until acknowledged.
  task automatic frame(logic [15:0] r0, logic pl, logic et, int k);
    refl_coef = '0;
    refl_coef[0] = r0;
    pole_low = pl;
    vad_decision = k[0];
    speech_frame_flag = ~k[0];
    p1 = k[0] ? 16'h7FFF : 16'h8000;
    p2 = ~p1;
    for (int j = 0; j < 9; j++) begin
      coef[j] = 16'((j % 2 ? -1 : 1) * (3000 * j + 700 + k));
      acf[j] = 32'((9 - j) * 200000 - 7 * k);
    end
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    @(posedge clk);
    while (!params_ack) @(posedge clk);
    #1;
    chk_flag("tone", et, tone);
    chk_flag("tone_uplink", 1'b0, up_tone);
    chk_num("energy", e_ref(), energy);
    chk_num("first_word", {k[0], p1[14:0]}, first_word);
    chk_num("second_word", {~k[0], p2[14:0]}, second_word);
  endtask

  // Error 1465 just misses the threshold, 1463 just meets it.
  task automatic t_tone();
    frame(16'h7D19, 1'b0, 1'b0, 0);
    frame(16'h7D1A, 1'b0, 1'b1, 1);
    frame(16'h8000, 1'b0, 1'b1, 2);
    frame(16'h0000, 1'b0, 1'b0, 3);
  endtask

  task automatic t_pole();
    frame(16'h8000, 1'b1, 1'b0, 4);
    frame(16'h8000, 1'b0, 1'b1, 5);
  endtask

  // Reset in mid-run must clear every held result and the sample path.
  task automatic t_reset();
    rstn = 1'b0;
    @(posedge clk);
    #1;
    chk_flag("tone_rst", 1'b0, tone);
    chk_num("energy_rst", 76'h0, energy);
    chk_num("first_word_rst", 16'h0000, first_word);
    chk_num("second_word_rst", 16'h0000, second_word);
    chk_flag("sample_ready_rst", 1'b0, sample_ready);
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    chk_flag("sample_ready_up", 1'b1, sample_ready);
  endtask

  // Full-scale negative input makes each output the negated table entry.
  task automatic t_stream();
    logic [15:0] y [160];
    sample_data = 16'h8000;
    fork
      begin
        for (int n = 0; n < 160; n++) begin
          sample_valid = 1'b1;
          @(posedge clk);
          while (!sample_ready) @(posedge clk);
          #1;
        end
        sample_valid = 1'b0;
      end
      begin
        repeat (60) @(posedge clk);
        chk_flag("sample_ready", 1'b0, sample_ready);
        #1 win_ready = 1'b1;
        for (int n = 0; n < 160; n++) begin
          @(posedge clk);
          while (!(win_valid && win_ready)) @(posedge clk);
          y[n] = win_data;
          chk_flag("win_last", n == 159, win_last);
          #1 win_ready = 1'b0;
          @(posedge clk);
          #1 win_ready = 1'b1;
        end
      end
    join
    chk_num("win_0", 16'h0000, y[0]);
    chk_num("win_40", 16'hBF5F, y[40]);
    chk_num("win_79", 16'h8004, y[79]);
    chk_num("win_119", 16'hBF5F, y[119]);
    for (int i = 0; i < 80; i++) begin
      chk_flag("win_sym", 1'b1, y[i] === y[159-i]);
      if (i < 79)
        chk_flag("win_rise", 1'b1, $signed(y[i+1]) <= $signed(y[i]));
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    {rstn, go, sample_valid, win_ready, pole_low} = '0;
    {vad_decision, speech_frame_flag, sample_data, p1, p2} = '0;
    {refl_coef, coef, acf} = '0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    t_tone();
    t_pole();
    t_reset();
    t_stream();
    give_verdict();
  end
endmodule
